//--- core/dacrd_top.sv
// Behaviour
// - Frame: R/W bit, 2-bit device address, 3-bit select, 2-bit channel, 16-bit data.
// - Select 100 writes payload to offset trim of the chosen channel.
// - Select 101 writes payload to offset trim of all four channels.
// - Select 110 writes payload to clear value of the chosen channel.
// - Select 111 passes frame on as a control-register access.
// - Channel bits ignored by selects 011 and 101; select 111 passes them on with the control access.
// - Select 010 writes payload to gain trim of the chosen channel.
// - Select 011 writes payload to gain trim of all four channels.
// - Gain trim is unsigned straight binary, 0 to 65535 LSBs.
// - Gain trim resets to all ones.
// - Offset trim minus midscale gives -32768 to +32767 LSBs.
// - Offset trim resets to midscale, meaning no adjustment.
// - Each channel holds a clear value loaded when clear input asserts.
// - Clear response is enabled separately per channel.
// - Clear value resets to zero.
// - Serial word is 24 bits.
// - Select 000 writes payload to output code of the chosen channel.
// - Frame acted on only when its device address matches address pins.
// - Top frame bit selects read or write; zero means write.
`include "dacrd_defs.svh"

module dacrd_top
    import dacrd_pkg::*;
#(
    parameter logic [15:0] CODE_RESET = 16'h0000
)
(
    input wire logic i_sys_clk,                       // System clock
    input wire logic i_reset,                         // Synchronous reset
    input wire logic i_link_sclk,                     // Serial link clock
    input wire logic i_sync_n,                        // Frame select, low
    input wire logic i_sdin,                          // Serial data in
    input wire logic i_hw_addr_pin_hi,                // Address pin, high bit
    input wire logic i_hw_addr_pin_lo,                // Address pin, low bit
    input wire logic i_clear,                         // Clear pin, high
    input wire logic [`DACRD_NUM_CH-1:0] i_clear_enable, // Per-channel clear enable
    output dacrd_chan_regs_t [`DACRD_NUM_CH-1:0] o_chan_regs, // Channel registers
    output logic [`DACRD_NUM_CH-1:0][16:0] o_offset_adjust, // Signed offset in LSBs
    output logic o_frame_accept,                      // Frame for this device
    output logic o_frame_foreign,                     // Frame for another device
    output logic o_ctrl_valid,                        // Control access pulse
    output dacrd_ctrl_req_t o_ctrl_req,               // Control access content
    output logic o_read_valid,                        // Read answer pulse
    output logic [15:0] o_read_data                   // Read answer data
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic dacrd_frame_t dacrd_unpack(input logic [`DACRD_FRAME_BITS-1:0] w);
        dacrd_frame_t f;
        f.rw = w[`DACRD_RW_BIT];
        f.device_select = {w[`DACRD_DEV_HI], w[`DACRD_DEV_LO]};
        f.reg_select = w[`DACRD_SEL_HI:`DACRD_SEL_LO];
        f.channel_select = w[`DACRD_CH_HI:`DACRD_CH_LO];
        f.payload = w[`DACRD_PAY_HI:`DACRD_PAY_LO];
        return f;
    endfunction

    // Straight binary minus midscale
    function automatic logic [16:0] dacrd_offset_lsbs(input logic [15:0] r);
        return {1'b0, r} - `DACRD_OFFSET_MID;
    endfunction

    // Channel A..D decoded to one-hot
    function automatic logic [`DACRD_NUM_CH-1:0] dacrd_chan_hot(input logic [1:0] c);
        return `DACRD_NUM_CH'(1) << c;
    endfunction

    // ****************************************************************
    // Link side receiver
    // ****************************************************************
    logic link_done;
    logic [`DACRD_FRAME_BITS-1:0] link_word;

    dacrd_frame_rx u_frame_rx (
        .i_link_sclk(i_link_sclk),
        .i_sync_n(i_sync_n),
        .i_sdin(i_sdin),
        .o_frame_done(link_done),
        .o_frame_word(link_word)
    );

    // ****************************************************************
    // Crossings and pin synchronisers
    // ****************************************************************
    logic done_meta_q;
    logic done_sync_q;
    logic done_seen_q;
    logic [1:0] addr_meta_q;
    logic [1:0] addr_sync_q;
    logic clear_meta_q;
    logic clear_sync_q;

    // Catches a done level shorter than one system cycle
    always_ff @(posedge i_sys_clk or posedge link_done) begin
        if (link_done) begin
            done_meta_q <= 1'b1;
        end else begin
            done_meta_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            done_sync_q <= 1'b0;
            done_seen_q <= 1'b0;
        end else begin
            done_sync_q <= done_meta_q;
            done_seen_q <= done_sync_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            addr_meta_q <= 2'h0;
            addr_sync_q <= 2'h0;
            clear_meta_q <= 1'b0;
            clear_sync_q <= 1'b0;
        end else begin
            addr_meta_q <= {i_hw_addr_pin_hi, i_hw_addr_pin_lo};
            addr_sync_q <= addr_meta_q;
            clear_meta_q <= i_clear;
            clear_sync_q <= clear_meta_q;
        end
    end

    // ****************************************************************
    // Frame capture
    // ****************************************************************
    logic frame_vld_q;
    dacrd_frame_t frame_q;
    logic frame_new;

    // Word is frozen in the link domain while its done level stands
    assign frame_new = done_sync_q && !done_seen_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            frame_vld_q <= 1'b0;
        end else begin
            frame_vld_q <= frame_new;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            frame_q <= '0;
        end else if (frame_new) begin
            frame_q <= dacrd_unpack(link_word);
        end
    end

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic addr_match;
    logic do_write;
    logic do_read;
    logic [`DACRD_NUM_CH-1:0] one_ch;
    logic [`DACRD_NUM_CH-1:0] wr_code;
    logic [`DACRD_NUM_CH-1:0] wr_gain;
    logic [`DACRD_NUM_CH-1:0] wr_offset;
    logic [`DACRD_NUM_CH-1:0] wr_clear;

    assign addr_match = frame_q.device_select == addr_sync_q;
    assign do_write = frame_vld_q && addr_match && !frame_q.rw;
    assign do_read = frame_vld_q && addr_match && frame_q.rw;
    assign one_ch = dacrd_chan_hot(frame_q.channel_select);

    always_comb begin
        wr_code = '0;
        wr_gain = '0;
        wr_offset = '0;
        wr_clear = '0;
        if (do_write) begin
            unique case (frame_q.reg_select)
                `DACRD_SEL_CODE: wr_code = one_ch;
                `DACRD_SEL_GAIN: wr_gain = one_ch;
                `DACRD_SEL_GAIN_ALL: wr_gain = '1;
                `DACRD_SEL_OFFSET: wr_offset = one_ch;
                `DACRD_SEL_OFFSET_ALL: wr_offset = '1;
                `DACRD_SEL_CLEAR: wr_clear = one_ch;
                default: wr_code = '0;
            endcase
        end
    end

    // ****************************************************************
    // Channel register bank
    // ****************************************************************
    logic [`DACRD_NUM_CH-1:0][15:0] code_q;
    logic [`DACRD_NUM_CH-1:0][15:0] gain_q;
    logic [`DACRD_NUM_CH-1:0][15:0] offset_q;
    logic [`DACRD_NUM_CH-1:0][15:0] clear_q;

    // Clear pin has priority over a code write in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            code_q <= {`DACRD_NUM_CH{CODE_RESET}};
        end else begin
            for (int ch = 0; ch < `DACRD_NUM_CH; ch++) begin
                if (clear_sync_q && i_clear_enable[ch]) begin
                    code_q[ch] <= clear_q[ch];
                end else if (wr_code[ch]) begin
                    code_q[ch] <= frame_q.payload;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            gain_q <= {`DACRD_NUM_CH{`DACRD_GAIN_RST}};
        end else begin
            for (int ch = 0; ch < `DACRD_NUM_CH; ch++) begin
                if (wr_gain[ch]) begin
                    gain_q[ch] <= frame_q.payload;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            offset_q <= {`DACRD_NUM_CH{`DACRD_OFFSET_RST}};
        end else begin
            for (int ch = 0; ch < `DACRD_NUM_CH; ch++) begin
                if (wr_offset[ch]) begin
                    offset_q[ch] <= frame_q.payload;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            clear_q <= {`DACRD_NUM_CH{`DACRD_CLEAR_RST}};
        end else begin
            for (int ch = 0; ch < `DACRD_NUM_CH; ch++) begin
                if (wr_clear[ch]) begin
                    clear_q[ch] <= frame_q.payload;
                end
            end
        end
    end

    always_comb begin
        for (int ch = 0; ch < `DACRD_NUM_CH; ch++) begin
            o_chan_regs[ch].output_code = code_q[ch];
            o_chan_regs[ch].gain_trim = gain_q[ch];
            o_chan_regs[ch].offset_trim = offset_q[ch];
            o_chan_regs[ch].clear_value = clear_q[ch];
            o_offset_adjust[ch] = dacrd_offset_lsbs(offset_q[ch]);
        end
    end

    // ****************************************************************
    // Control access hand-off
    // ****************************************************************
    logic ctrl_vld_q;
    dacrd_ctrl_req_t ctrl_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            ctrl_vld_q <= 1'b0;
            ctrl_q <= '0;
        end else begin
            ctrl_vld_q <= frame_vld_q && addr_match && (frame_q.reg_select == `DACRD_SEL_CTRL);
            if (frame_vld_q && addr_match && (frame_q.reg_select == `DACRD_SEL_CTRL)) begin
                ctrl_q <= '{frame_q.rw, frame_q.channel_select, frame_q.payload};
            end
        end
    end

    assign o_ctrl_valid = ctrl_vld_q;
    assign o_ctrl_req = ctrl_q;

    // ****************************************************************
    // Read back
    // ****************************************************************
    logic rd_vld_q;
    logic [15:0] rd_data_q;
    logic [15:0] rd_mux;

    always_comb begin
        unique case (frame_q.reg_select)
            `DACRD_SEL_CODE: rd_mux = code_q[frame_q.channel_select];
            `DACRD_SEL_GAIN: rd_mux = gain_q[frame_q.channel_select];
            `DACRD_SEL_OFFSET: rd_mux = offset_q[frame_q.channel_select];
            `DACRD_SEL_CLEAR: rd_mux = clear_q[frame_q.channel_select];
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rd_vld_q <= 1'b0;
            rd_data_q <= 16'h0000;
        end else begin
            rd_vld_q <= do_read && (frame_q.reg_select != `DACRD_SEL_CTRL);
            if (do_read && (frame_q.reg_select != `DACRD_SEL_CTRL)) begin
                rd_data_q <= rd_mux;
            end
        end
    end

    assign o_read_valid = rd_vld_q;
    assign o_read_data = rd_data_q;

    // ****************************************************************
    // Frame status
    // ****************************************************************
    logic accept_q;
    logic foreign_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            accept_q <= 1'b0;
            foreign_q <= 1'b0;
        end else begin
            accept_q <= frame_vld_q && addr_match;
            foreign_q <= frame_vld_q && !addr_match;
        end
    end

    assign o_frame_accept = accept_q;
    assign o_frame_foreign = foreign_q;

endmodule

//--- core/dacrd_defs.svh
`ifndef DACRD_DEFS_SVH
`define DACRD_DEFS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define DACRD_FRAME_BITS 24
`define DACRD_CNT_W 5
`define DACRD_NUM_CH 4
`define DACRD_RW_BIT 23
`define DACRD_DEV_HI 22
`define DACRD_DEV_LO 21
`define DACRD_SEL_HI 20
`define DACRD_SEL_LO 18
`define DACRD_CH_HI 17
`define DACRD_CH_LO 16
`define DACRD_PAY_HI 15
`define DACRD_PAY_LO 0

// ****************************************************************
// Register select codes
// ****************************************************************
`define DACRD_SEL_CODE 3'h0
`define DACRD_SEL_GAIN 3'h2
`define DACRD_SEL_GAIN_ALL 3'h3
`define DACRD_SEL_OFFSET 3'h4
`define DACRD_SEL_OFFSET_ALL 3'h5
`define DACRD_SEL_CLEAR 3'h6
`define DACRD_SEL_CTRL 3'h7

// ****************************************************************
// Reset values
// ****************************************************************
`define DACRD_GAIN_RST 16'hffff
`define DACRD_OFFSET_RST 16'h8000
`define DACRD_CLEAR_RST 16'h0000
`define DACRD_OFFSET_MID 17'h08000

`endif

//--- core/dacrd_pkg.sv
`include "dacrd_defs.svh"

package dacrd_pkg;

    // Decoded serial frame
    typedef struct packed {
        logic        rw;
        logic [1:0]  device_select;
        logic [2:0]  reg_select;
        logic [1:0]  channel_select;
        logic [15:0] payload;
    } dacrd_frame_t;

    // Per-channel data-path registers
    typedef struct packed {
        logic [15:0] output_code;
        logic [15:0] gain_trim;
        logic [15:0] offset_trim;
        logic [15:0] clear_value;
    } dacrd_chan_regs_t;

    // Control-register access passed on for further decoding
    typedef struct packed {
        logic        rw;
        logic [1:0]  channel_select;
        logic [15:0] payload;
    } dacrd_ctrl_req_t;

endpackage

//--- core/dacrd_frame_rx.sv
`include "dacrd_defs.svh"

module dacrd_frame_rx
    import dacrd_pkg::*;
(
    input wire logic i_link_sclk,                     // Serial clock from host
    input wire logic i_sync_n,                        // Frame select, low in frame
    input wire logic i_sdin,                          // Serial data in
    output logic o_frame_done,                        // Full frame held
    output logic [`DACRD_FRAME_BITS-1:0] o_frame_word // Received word
);

    localparam logic [`DACRD_CNT_W-1:0] FULL = `DACRD_CNT_W'(`DACRD_FRAME_BITS);

    logic [`DACRD_CNT_W-1:0] bit_cnt_q;
    logic done_q;
    logic [`DACRD_FRAME_BITS-1:0] shift_q;

    // ****************************************************************
    // Bit count, cleared while the frame select is idle
    // ****************************************************************
    always_ff @(negedge i_link_sclk or posedge i_sync_n) begin
        if (i_sync_n) begin
            bit_cnt_q <= '0;
            done_q <= 1'b0;
        end else if (bit_cnt_q != FULL) begin
            bit_cnt_q <= bit_cnt_q + `DACRD_CNT_W'(1);
            done_q <= (bit_cnt_q == FULL - `DACRD_CNT_W'(1));
        end
    end

    // ****************************************************************
    // Shift in MSB first; frozen once the word is complete
    // ****************************************************************
    always_ff @(negedge i_link_sclk) begin
        if (!i_sync_n && bit_cnt_q != FULL) begin
            shift_q <= {shift_q[`DACRD_FRAME_BITS-2:0], i_sdin};
        end
    end

    assign o_frame_done = done_q;
    assign o_frame_word = shift_q;

endmodule

//--- testbench/dacrd_top_properties.sv
module dacrd_top_properties
    import dacrd_pkg::*;
(
    input wire logic i_sys_clk, // System clock
    input wire logic i_reset, // Sync reset
    input wire logic i_clear, // Clear pin
    input wire logic [3:0] i_clear_enable, // Clear enables
    input wire dacrd_chan_regs_t [3:0] o_chan_regs, // Registers
    input wire logic [3:0][16:0] o_offset_adjust, // Offset in LSBs
    input wire logic o_frame_accept, // Own frame
    input wire logic o_frame_foreign, // Foreign frame
    input wire logic o_ctrl_valid, // Control pulse
    input wire dacrd_ctrl_req_t o_ctrl_req, // Control content
    input wire logic o_read_valid, // Read pulse
    input wire logic [15:0] o_read_data // Read data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic adj_ok;
    logic [191:0] trims;

    always_comb begin
        adj_ok = 1'b1;
        for (int c = 0; c < 4; c++) begin
            trims[c*48 +: 48] = {o_chan_regs[c].gain_trim, o_chan_regs[c].offset_trim,
                o_chan_regs[c].clear_value};
            if (o_offset_adjust[c] != {1'b0, o_chan_regs[c].offset_trim} - 17'h08000) begin
                adj_ok = 1'b0;
            end
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    AST_PULSE_ONE: assert property (o_frame_accept |=> !o_frame_accept)
        else $error("accept pulse too long");
    AST_ADDR_EXCL: assert property (!(o_frame_accept && o_frame_foreign))
        else $error("accept and foreign together");
    AST_OFFSET_ADJ: assert property (adj_ok)
        else $error("offset adjust wrong");
    AST_TRIM_ON_ACCEPT: assert property ($changed(trims) |-> o_frame_accept)
        else $error("trim changed without frame");
    AST_CTRL_OWN: assert property (o_ctrl_valid |-> o_frame_accept)
        else $error("control pulse without accept");
    AST_READ_OWN: assert property (o_read_valid |-> o_frame_accept && !o_ctrl_valid)
        else $error("read pulse wrong");
    AST_CTRL_HOLD: assert property (!o_ctrl_valid |-> $stable(o_ctrl_req))
        else $error("control content moved");
    AST_READ_HOLD: assert property (!o_read_valid |-> $stable(o_read_data))
        else $error("read data moved");
    AST_CLEAR_LOAD: assert property ((i_clear && i_clear_enable[0])[*3] |=>
        o_chan_regs[0].output_code == o_chan_regs[0].clear_value)
        else $error("clear value not loaded");
endmodule

bind dacrd_top dacrd_top_properties u_props (.i_sys_clk, .i_reset, .i_clear, .i_clear_enable,
    .o_chan_regs, .o_offset_adjust, .o_frame_accept, .o_frame_foreign, .o_ctrl_valid,
    .o_ctrl_req, .o_read_valid, .o_read_data);

//--- testbench/dacrd_host_model.sv
module dacrd_host_model (
    output logic o_sclk, // Link clock, idle high
    output logic o_sync_n, // Frame select
    output logic o_sdin // Serial data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_sclk = 1'b1;
        o_sync_n = 1'b1;
        o_sdin = 1'b0;
    end

    // Sends nbits MSB first; stall slows the host
    task automatic send(input logic [23:0] word, input int nbits, input int stall);
        o_sync_n = 1'b0;
        #3;
        for (int i = 23; i > 23 - nbits; i--) begin
            o_sdin = word[i];
            #3 o_sclk = 1'b0;
            #3 o_sclk = 1'b1;
            #(stall);
        end
        #3 o_sync_n = 1'b1;
        o_sdin = ~o_sdin; // Released line shows no stale bit
    endtask
endmodule

//--- testbench/dacrd_top_bench.sv
module dacrd_top_bench
    import dacrd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [1:0] DEV = 2'h2;
    logic clk, rst, clr, acc, forn, cval, rval;
    logic [1:0] pins;
    logic [3:0] clr_en;
    logic sclk, sync_n, sdin;
    dacrd_chan_regs_t [3:0] regs;
    dacrd_chan_regs_t [3:0] exp_r;
    logic [3:0][16:0] adj;
    dacrd_ctrl_req_t creq;
    logic [15:0] rdata;
    int n_mismatch = 0, check_count = 0, n_acc = 0, n_for = 0, n_ctl = 0, n_rd = 0;

    dacrd_host_model u_host (.o_sclk(sclk), .o_sync_n(sync_n), .o_sdin(sdin));
    dacrd_top u_dut (.i_sys_clk(clk), .i_reset(rst), .i_link_sclk(sclk), .i_sync_n(sync_n),
        .i_sdin(sdin), .i_hw_addr_pin_hi(pins[1]), .i_hw_addr_pin_lo(pins[0]), .i_clear(clr),
        .i_clear_enable(clr_en), .o_chan_regs(regs), .o_offset_adjust(adj),
        .o_frame_accept(acc), .o_frame_foreign(forn), .o_ctrl_valid(cval),
        .o_ctrl_req(creq), .o_read_valid(rval), .o_read_data(rdata));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    always @(posedge clk) begin
        if (acc === 1'b1) n_acc++;
        if (forn === 1'b1) n_for++;
        if (cval === 1'b1) n_ctl++;
        if (rval === 1'b1) n_rd++;
    end

    // ********************
    // Helpers
    // ********************
    function automatic logic [23:0] fw(logic rw, logic [1:0] dv, logic [2:0] sl, logic [1:0] ch,
        logic [15:0] d);
        return {rw, dv, sl, ch, d};
    endfunction

    task automatic check(input string name, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic cmp_all();
        for (int c = 0; c < 4; c++) begin
            check("chan_regs", exp_r[c], regs[c]);
            check("offset_adjust", 17'({1'b0, exp_r[c].offset_trim} - 17'h08000), adj[c]);
        end
    endtask

    task automatic frame(input logic [23:0] w, input int n, input int stall);
        u_host.send(w, n, stall);
        repeat (10) @(posedge clk);
        #1;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_reset();
        for (int c = 0; c < 4; c++) begin
            exp_r[c] = '{16'h0000, 16'hffff, 16'h8000, 16'h0000};
        end
        cmp_all();
    endtask

    task automatic t_single();
        logic [2:0] sels [4] = '{3'h0, 3'h2, 3'h4, 3'h6};
        logic [15:0] d;
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 4; c++) begin
                d = {sels[s], 2'(c), 11'h2a5};
                frame(fw(1'b0, DEV, sels[s], 2'(c), d), 24, s * 3);
                case (s)
                    0: exp_r[c].output_code = d;
                    1: exp_r[c].gain_trim = d;
                    2: exp_r[c].offset_trim = d;
                    default: exp_r[c].clear_value = d;
                endcase
                cmp_all();
            end
        end
        check("accepts", 16, n_acc);
    endtask

    task automatic t_all();
        logic [15:0] v [2] = '{16'h0000, 16'hffff};
        for (int k = 0; k < 2; k++) begin
            frame(fw(1'b0, DEV, 3'h3, 2'(k + 1), v[k]), 24, 0);
            frame(fw(1'b0, DEV, 3'h5, 2'(k + 2), v[k]), 24, 0);
            for (int c = 0; c < 4; c++) begin
                exp_r[c].gain_trim = v[k];
                exp_r[c].offset_trim = v[k];
            end
            cmp_all();
        end
    endtask

    task automatic t_refuse();
        frame(fw(1'b0, 2'h1, 3'h2, 2'h0, 16'h0bad), 24, 0);
        frame(fw(1'b0, DEV, 3'h2, 2'h0, 16'h0bad), 20, 0);
        frame(fw(1'b0, DEV, 3'h1, 2'h0, 16'h0bad), 24, 0);
        cmp_all();
        check("foreign", 1, n_for);
        pins = 2'h1;
        repeat (3) @(posedge clk);
        #1;
        frame(fw(1'b0, 2'h1, 3'h6, 2'h3, 16'h0c3c), 24, 0);
        exp_r[3].clear_value = 16'h0c3c;
        cmp_all();
        pins = DEV;
        check("accepts", 22, n_acc);
    endtask

    task automatic t_read_ctrl();
        frame(fw(1'b1, DEV, 3'h6, 2'h0, 16'h0000), 24, 0);
        check("read_data", exp_r[0].clear_value, rdata);
        for (int s = 0; s < 3; s++) begin
            frame(fw(1'b1, DEV, 3'(s * 2), 2'(s + 1), 16'h0000), 24, 0);
            check("read_data", exp_r[s + 1][63 - s * 16 -: 16], rdata);
        end
        check("reads", 4, n_rd);
        frame(fw(1'b0, DEV, 3'h7, 2'h2, 16'h2a5c), 24, 0);
        check("ctrl_req", {1'b0, 2'h2, 16'h2a5c}, creq);
        check("ctrls", 1, n_ctl);
        cmp_all();
    endtask

    task automatic t_clear();
        clr = 1'b1;
        repeat (6) @(posedge clk);
        #1 clr = 1'b0;
        for (int c = 0; c < 4; c++) begin
            if (clr_en[c]) exp_r[c].output_code = exp_r[c].clear_value;
        end
        repeat (4) @(posedge clk);
        #1;
        cmp_all();
    endtask

    initial begin
        rst = 1'b1;
        clr = 1'b0;
        clr_en = 4'h5;
        pins = DEV;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk) #1;
        t_reset();
        t_single();
        t_all();
        t_refuse();
        t_read_ctrl();
        t_clear();
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk) #1;
        t_reset();
        final_report();
    end

    initial begin
        #200_000;
        n_mismatch++;
        $display("watchdog expired");
        final_report();
    end
endmodule
